// ==== common/analog_io_count_formatter_params.svh ====
// Constants for the fixed analog channel count formatter
`ifndef ANALOG_IO_COUNT_FORMATTER_PARAMS_SVH
`define ANALOG_IO_COUNT_FORMATTER_PARAMS_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define MCLK_HZ            50000000
`define CH_REFRESH_MS      50
`define SCAN_MS            200
`define REFRESH_CYCLES     (`CH_REFRESH_MS * (`MCLK_HZ / 1000))
`define REFRESH_CNT_W      22
// ****************************************************************
// Channel layout and reset values
// ****************************************************************
`define AIN_CHANNELS       4
`define AOUT_CHANNELS      2
`define STATUS_INDEX       4
`define STAT_WARN_BIT(ch)  (2 * (ch))
`define STAT_OOR_BIT(ch)   (2 * (ch) + 1)
`define WORD_RESET         16'h0000
`define CODE_RESET         12'h000
`define CODE_MAX           12'hFFF
// ****************************************************************
// Raw code thresholds, raw LSB is 20.48 V / 65536
// ****************************************************************
`define RAW_ZERO           18'sd0
`define RAW_MIN            (-18'sd32768)
`define RAW_MAX            18'sd32767
`define RAW_NEG_10V        (-18'sd32000)
`define RAW_POS_10V        18'sd32000
`define RAW_POS_9V995      18'sd31984
`define RAW_POS_9V9976     18'sd31992
`define RAW_0V52           18'sd1664
`define RAW_1V             18'sd3200
`define RAW_4V999          18'sd15997
`define RAW_5V             18'sd16000
`define RAW_5V12           18'sd16384
// ****************************************************************
// Scaling and saturation counts
// ****************************************************************
`define SCALE_U12          16'h20C5
`define SCALE_B12          16'h1063
`define SCALE_R12          16'h51EC
`define CNT_ZERO           16'h0000
`define CNT12_MAX          16'h0FFF
`define CNT15_OVER         16'h7FFF
`define CNT14_OVER         16'h3380
`define CNT16_OVER         16'hFFFF
`endif

// ==== common/analog_io_pkg.sv ====
// Types shared by the analog channel formatter blocks
`include "analog_io_count_formatter_params.svh"
package analog_io_pkg;
    // Range and resolution selection
    typedef enum logic [2:0] {
        range_unipolar10_12bit = 3'h0,
        range_1to5_12bit       = 3'h1,
        range_bipolar10_12bit  = 3'h2,
        range_unipolar10_15bit = 3'h3,
        range_1to5_14bit       = 3'h4,
        range_bipolar10_16bit  = 3'h5
    } range_e;
    // Formatted count with its channel flags
    typedef struct packed {
        logic [15:0] count;
        logic        warn;
        logic        oor;
    } fmt_s;
    // Conversion request towards the front end
    typedef struct packed {
        logic       req;
        logic [1:0] chan;
    } conv_req_s;
    // Conversion answer from the front end
    typedef struct packed {
        logic        valid;
        logic [15:0] raw;
    } conv_rsp_s;
endpackage : analog_io_pkg

// ==== core/analog_io_count_formatter.sv ====
// Fixed analog channel formatter: input scan, count scaling, outputs
`include "analog_io_count_formatter_params.svh"
module analog_io_count_formatter
    import analog_io_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = `REFRESH_CYCLES
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire range_e           range_sel,
    output conv_req_s             conv_req,
    input  wire conv_rsp_s        conv_rsp,
    output logic [4:0][15:0]      ain_image,
    output logic                  ain_upd,
    output logic [1:0]            ain_upd_chan,
    input  wire logic [1:0][15:0] aout_word,
    output logic [1:0][11:0]      aout_code
);
    // ****************************************************************
    // Scaling helper
    // ****************************************************************
    // Fixed point multiply avoids a divider; results saturate at 4095
    function automatic logic [15:0] sat_scale(input logic signed [17:0] d,
                                              input logic [15:0]        k);
        logic [33:0] prod;
        logic [17:0] q;
        prod = 34'(d[16:0]) * 34'(k);
        q    = prod[33:16];
        if (d < `RAW_ZERO) begin
            sat_scale = `CNT_ZERO;
        end else if (q > 18'(`CNT12_MAX)) begin
            sat_scale = `CNT12_MAX;
        end else begin
            sat_scale = {4'h0, q[11:0]};
        end
    endfunction : sat_scale

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    typedef enum logic [2:0] {
        seq_wait_tick = 3'b001,
        seq_request   = 3'b010,
        seq_convert   = 3'b100
    } seq_e;

    seq_e        state_ff;
    seq_e        nxt_state;
    logic [1:0]  chan_ff;
    logic        upd_ff;
    logic [1:0]  upd_chan_ff;
    logic [15:0] word_ff  [`AIN_CHANNELS];
    fmt_s        flags_ff [`AIN_CHANNELS];
    logic        tick;
    fmt_s        fmt;
    wire logic   capture = (state_ff == seq_convert) && conv_rsp.valid;
    wire logic   last_ch = (chan_ff == 2'(`AIN_CHANNELS - 1));

    // Per-channel refresh pacing
    refresh_timer #(
        .CYCLES (REFRESH_CYCLES)
    ) u_refresh (
        .mclk    (mclk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    // ****************************************************************
    // Raw code per range
    // ****************************************************************
    logic signed [17:0] rs;
    logic signed [17:0] d_u12;
    logic signed [17:0] d_r12;
    logic signed [17:0] d_b12;
    logic signed [17:0] d_r14;
    fmt_s               f_u12;
    fmt_s               f_r12;
    fmt_s               f_b12;
    fmt_s               f_u15;
    fmt_s               f_r14;
    fmt_s               f_b16;

    // Raw code kept at full width, sign extended for the offsets
    assign rs    = {{2{conv_rsp.raw[15]}}, conv_rsp.raw};
    assign d_u12 = rs;
    assign d_r12 = rs - `RAW_1V;
    assign d_b12 = rs - `RAW_NEG_10V;
    assign d_r14 = rs - `RAW_1V;

    // Unipolar 12-bit; the converter saturates below 10.24 V, so its top code means over
    assign f_u12 = (rs < `RAW_ZERO)       ? {`CNT_ZERO, 1'b1, 1'b1} :
                   (rs == `RAW_MAX)       ? {`CNT12_MAX, 1'b0, 1'b1} :
                   (rs > `RAW_POS_9V9976) ? {`CNT12_MAX, 1'b1, 1'b0} :
                   {sat_scale(d_u12, `SCALE_U12), 2'b00};

    // 1 to 5 V, 12-bit
    assign f_r12 = (rs < `RAW_0V52)   ? {`CNT_ZERO, 1'b1, 1'b1} :
                   (rs < `RAW_1V)     ? {`CNT_ZERO, 1'b1, 1'b0} :
                   (rs >= `RAW_5V12)  ? {`CNT12_MAX, 1'b1, 1'b1} :
                   (rs > `RAW_4V999)  ? {`CNT12_MAX, 1'b1, 1'b0} :
                   {sat_scale(d_r12, `SCALE_R12), 2'b00};

    // Bipolar 12-bit
    assign f_b12 = (rs == `RAW_MIN)      ? {`CNT_ZERO, 1'b1, 1'b1} :
                   (rs < `RAW_NEG_10V)   ? {`CNT_ZERO, 1'b1, 1'b0} :
                   (rs == `RAW_MAX)      ? {`CNT12_MAX, 1'b1, 1'b1} :
                   (rs > `RAW_POS_9V995) ? {`CNT12_MAX, 1'b1, 1'b0} :
                   {sat_scale(d_b12, `SCALE_B12), 2'b00};

    // Unipolar 15-bit: count equals the raw code, negative codes read 0
    assign f_u15 = (rs < `RAW_ZERO)    ? {`CNT_ZERO, 1'b1, 1'b1} :
                   (rs == `RAW_MAX)    ? {`CNT15_OVER, 1'b1, 1'b1} :
                   (rs > `RAW_POS_10V) ? {conv_rsp.raw, 1'b1, 1'b0} :
                   {conv_rsp.raw, 2'b00};

    // 1 to 5 V, 14-bit: high band carries the out-of-range bit alone
    assign f_r14 = (rs < `RAW_0V52)  ? {`CNT_ZERO, 1'b1, 1'b1} :
                   (rs < `RAW_1V)    ? {`CNT_ZERO, 1'b1, 1'b0} :
                   (rs >= `RAW_5V12) ? {`CNT14_OVER, 1'b1, 1'b1} :
                   (rs > `RAW_5V)    ? {d_r14[15:0], 1'b0, 1'b1} :
                   {d_r14[15:0], 2'b00};

    // Bipolar 16-bit: offset binary, -10 V lands on 768
    assign f_b16 = (rs == `RAW_MIN)    ? {`CNT_ZERO, 1'b1, 1'b1} :
                   (rs < `RAW_NEG_10V) ? {~conv_rsp.raw[15], conv_rsp.raw[14:0], 1'b1, 1'b0} :
                   (rs == `RAW_MAX)    ? {`CNT16_OVER, 1'b0, 1'b1} :
                   (rs > `RAW_POS_10V) ? {~conv_rsp.raw[15], conv_rsp.raw[14:0], 1'b1, 1'b0} :
                   {~conv_rsp.raw[15], conv_rsp.raw[14:0], 2'b00};

    // Range selection; an unused code reads as the 12-bit unipolar range
    always_comb begin
        case (range_sel)
            range_unipolar10_12bit: fmt = f_u12;
            range_1to5_12bit:       fmt = f_r12;
            range_bipolar10_12bit:  fmt = f_b12;
            range_unipolar10_15bit: fmt = f_u15;
            range_1to5_14bit:       fmt = f_r14;
            range_bipolar10_16bit:  fmt = f_b16;
            default:                fmt = f_u12;
        endcase
    end

    // ****************************************************************
    // Scan sequencer
    // ****************************************************************
    // A tick that lands during a slow conversion is dropped, not queued
    always_comb begin
        case (state_ff)
            seq_wait_tick: nxt_state = tick ? seq_request : seq_wait_tick;
            seq_request:   nxt_state = seq_convert;
            seq_convert:   nxt_state = conv_rsp.valid ? seq_wait_tick : seq_convert;
            default:       nxt_state = seq_wait_tick;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff    <= seq_wait_tick;
            chan_ff     <= 2'h0;
            upd_ff      <= 1'b0;
            upd_chan_ff <= 2'h0;
        end else begin
            state_ff    <= nxt_state;
            chan_ff     <= capture ? (last_ch ? 2'h0 : chan_ff + 2'h1) : chan_ff;
            upd_ff      <= capture;
            upd_chan_ff <= capture ? chan_ff : upd_chan_ff;
        end
    end

    assign conv_req.req  = (state_ff == seq_request);
    assign conv_req.chan = chan_ff;
    assign ain_upd       = upd_ff;
    assign ain_upd_chan  = upd_chan_ff;

    // ****************************************************************
    // Channel words and status word
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `AIN_CHANNELS; g++) begin : g_ain
            // Count and flags land in the same edge
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    word_ff[g]  <= `WORD_RESET;
                    flags_ff[g] <= '0;
                end else if (capture && chan_ff == 2'(g)) begin
                    word_ff[g]  <= fmt.count;
                    flags_ff[g] <= fmt;
                end
            end
            assign ain_image[g]                        = word_ff[g];
            assign ain_image[`STATUS_INDEX][`STAT_WARN_BIT(g)] = flags_ff[g].warn;
            assign ain_image[`STATUS_INDEX][`STAT_OOR_BIT(g)]  = flags_ff[g].oor;
        end
        for (g = 0; g < `AOUT_CHANNELS; g++) begin : g_aout
            aout_clamp u_clamp (
                .mclk    (mclk),
                .reset_n (reset_n),
                .word    (aout_word[g]),
                .code    (aout_code[g])
            );
        end
    endgenerate
    assign ain_image[`STATUS_INDEX][15:8] = 8'h00;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    localparam logic [`REFRESH_CNT_W-1:0] GAP_EXP = `REFRESH_CNT_W'(REFRESH_CYCLES - 1);
    logic [`REFRESH_CNT_W-1:0] gap_ff;
    logic                      seen_ff;
    logic [1:0]                last_ch_ff;
    wire logic [15:0]          last_word = word_ff[last_ch_ff];
    wire logic                 last_warn = flags_ff[last_ch_ff].warn;
    wire logic                 last_oor  = flags_ff[last_ch_ff].oor;

    // Helper logic measuring the tick spacing
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff     <= '0;
            seen_ff    <= 1'b0;
            last_ch_ff <= 2'h0;
        end else begin
            gap_ff     <= tick ? '0 : gap_ff + 1'b1;
            seen_ff    <= seen_ff | tick;
            last_ch_ff <= capture ? chan_ff : last_ch_ff;
        end
    end

    property p_refresh_period;
        (tick && seen_ff) |-> (gap_ff == GAP_EXP);
    endproperty
    a_refresh_period: assert property (p_refresh_period) else $error("tick spacing wrong");

    property p_tick_request;
        (tick && state_ff == seq_wait_tick) |=> conv_req.req ##1 !conv_req.req;
    endproperty
    a_tick_request: assert property (p_tick_request) else $error("no request on tick");

    property p_status_follows;
        ain_upd |-> (ain_image[`STATUS_INDEX][`STAT_WARN_BIT(ain_upd_chan)] == last_warn)
                    && (ain_image[ain_upd_chan] == last_word);
    endproperty
    a_status_follows: assert property (p_status_follows) else $error("status out of step");

    property p_status_tail;
        ain_image[`STATUS_INDEX][15:8] == 8'h00;
    endproperty
    a_status_tail: assert property (p_status_tail) else $error("status high bits set");

    property p_u12_under;
        (capture && range_sel == range_unipolar10_12bit && rs < `RAW_ZERO)
            |=> (last_word == `CNT_ZERO) && last_warn && last_oor;
    endproperty
    a_u12_under: assert property (p_u12_under) else $error("unipolar 12 under wrong");

    property p_u12_over;
        (capture && range_sel == range_unipolar10_12bit && rs == `RAW_MAX)
            |=> (last_word == `CNT12_MAX) && last_oor && !last_warn;
    endproperty
    a_u12_over: assert property (p_u12_over) else $error("unipolar 12 over wrong");

    property p_r12_low_warn;
        (capture && range_sel == range_1to5_12bit && rs >= `RAW_0V52 && rs < `RAW_1V)
            |=> (last_word == `CNT_ZERO) && last_warn && !last_oor;
    endproperty
    a_r12_low_warn: assert property (p_r12_low_warn) else $error("1-5 12 low band wrong");

    property p_r12_over;
        (capture && range_sel == range_1to5_12bit && rs >= `RAW_5V12)
            |=> (last_word == `CNT12_MAX) && last_warn && last_oor;
    endproperty
    a_r12_over: assert property (p_r12_over) else $error("1-5 12 over wrong");

    property p_b12_mid;
        (capture && range_sel == range_bipolar10_12bit && rs == `RAW_ZERO)
            |=> (last_word == 16'h0800) && !last_warn;
    endproperty
    a_b12_mid: assert property (p_b12_mid) else $error("bipolar 12 midpoint wrong");

    property p_b12_high_warn;
        (capture && range_sel == range_bipolar10_12bit && rs > `RAW_POS_9V995 && rs < `RAW_MAX)
            |=> (last_word == `CNT12_MAX) && last_warn && !last_oor;
    endproperty
    a_b12_high_warn: assert property (p_b12_high_warn) else $error("bipolar 12 high wrong");

    property p_u15_over;
        (capture && range_sel == range_unipolar10_15bit && rs == `RAW_MAX)
            |=> (last_word == `CNT15_OVER) && last_warn && last_oor;
    endproperty
    a_u15_over: assert property (p_u15_over) else $error("unipolar 15 over wrong");

    property p_b16_floor;
        (capture && range_sel == range_bipolar10_16bit && rs == `RAW_NEG_10V)
            |=> (last_word == 16'h0300) && !last_warn && !last_oor;
    endproperty
    a_b16_floor: assert property (p_b16_floor) else $error("bipolar 16 floor wrong");

    property p_b16_over;
        (capture && range_sel == range_bipolar10_16bit && rs == `RAW_MAX)
            |=> (last_word == `CNT16_OVER) && last_oor;
    endproperty
    a_b16_over: assert property (p_b16_over) else $error("bipolar 16 over wrong");

    property p_r14_high;
        (capture && range_sel == range_1to5_14bit && rs > `RAW_5V && rs < `RAW_5V12)
            |=> (last_word >= 16'h3201) && (last_word <= 16'h337F) && last_oor && !last_warn;
    endproperty
    a_r14_high: assert property (p_r14_high) else $error("1-5 14 high band wrong");

    property p_r14_under;
        (capture && range_sel == range_1to5_14bit && rs < `RAW_0V52)
            |=> (last_word == `CNT_ZERO) && last_warn && last_oor;
    endproperty
    a_r14_under: assert property (p_r14_under) else $error("1-5 14 under wrong");

    // Main scenarios
    c_full_scan:  cover property (ain_upd && ain_upd_chan == 2'h3);
    c_b16_warn:   cover property (capture && range_sel == range_bipolar10_16bit && fmt.warn);
    c_r14_over:   cover property (capture && range_sel == range_1to5_14bit && fmt.oor);
    c_slow_conv:  cover property (conv_req.req ##1 !conv_rsp.valid [*3] ##1 conv_rsp.valid);
endmodule : analog_io_count_formatter

// ==== core/aout_clamp.sv ====
// One analog output channel: clamps a data word to a 12-bit code
`include "analog_io_count_formatter_params.svh"
module aout_clamp
    import analog_io_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [15:0] word,
    output logic      [11:0] code
);
    // ****************************************************************
    // Clamp
    // ****************************************************************
    // Word is read as signed so a negative value pins to the low end
    logic [11:0] code_ff;
    wire logic   is_neg  = word[15];
    wire logic   is_high = (word[14:12] != 3'h0);
    wire logic [11:0] nxt_code = is_neg ? `CODE_RESET :
                                 is_high ? `CODE_MAX : word[11:0];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            code_ff <= `CODE_RESET;
        end else begin
            code_ff <= nxt_code;
        end
    end
    assign code = code_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_aout_low;
        @(posedge mclk) disable iff (!reset_n) word[15] |=> (code == `CODE_RESET);
    endproperty
    a_aout_low: assert property (p_aout_low) else $error("negative word not clamped");
    property p_aout_high;
        @(posedge mclk) disable iff (!reset_n)
            (!word[15] && word[14:12] != 3'h0) |=> (code == `CODE_MAX);
    endproperty
    a_aout_high: assert property (p_aout_high) else $error("high word not clamped");
    property p_aout_pass;
        @(posedge mclk) disable iff (!reset_n)
            (word[15:12] == 4'h0) |=> (code == $past(word[11:0]));
    endproperty
    a_aout_pass: assert property (p_aout_pass) else $error("code lost");
endmodule : aout_clamp

// ==== core/refresh_timer.sv ====
// Free running per-channel refresh tick generator
`include "analog_io_count_formatter_params.svh"
module refresh_timer
    import analog_io_pkg::*;
#(
    parameter int unsigned CYCLES = `REFRESH_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    output logic      tick
);
    // ****************************************************************
    // Down counter
    // ****************************************************************
    localparam logic [`REFRESH_CNT_W-1:0] RELOAD = `REFRESH_CNT_W'(CYCLES - 1);
    logic [`REFRESH_CNT_W-1:0] cnt_ff;
    logic                      tick_ff;
    wire logic                 at_zero = (cnt_ff == '0);

    // Reload on zero, so the tick period is exactly CYCLES edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= at_zero ? RELOAD : cnt_ff - 1'b1;
            tick_ff <= at_zero;
        end
    end
    assign tick = tick_ff;
endmodule : refresh_timer

// ==== verification/analog_io_count_formatter_test.sv ====
// Self-checking bench for the analog channel count formatter
// ****************************************************************
// Bench
// ****************************************************************
module analog_io_count_formatter_test
    import analog_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 20;
    logic mclk, reset_n, ain_upd;
    range_e range_sel;
    conv_req_s conv_req;
    conv_rsp_s conv_rsp;
    logic [4:0][15:0] ain_image;
    logic [1:0] ain_upd_chan, lag, ch;
    logic [1:0][15:0] aout_word;
    logic [1:0][11:0] aout_code;
    logic [15:0] raw, st;
    int seed = 32'h19936BF7, failures = 0, compares = 0, n, x, r;
    longint tp;
    fmt_s e;
    int corner[20] = '{-32768, -32001, -32000, -1, 0, 1663, 1664, 3199, 3200, 15997, 15998,
                       16000, 16001, 16383, 16384, 31984, 31985, 31993, 32001, 32767};
    analog_io_count_formatter #(.REFRESH_CYCLES(RC)) DUT (.mclk(mclk), .reset_n(reset_n),
        .range_sel(range_sel), .conv_req(conv_req), .conv_rsp(conv_rsp),
        .ain_image(ain_image), .ain_upd(ain_upd), .ain_upd_chan(ain_upd_chan),
        .aout_word(aout_word), .aout_code(aout_code));
    conv_front_end fe (.mclk(mclk), .reset_n(reset_n), .conv_req(conv_req), .raw_in(raw),
        .lag(lag), .conv_rsp(conv_rsp));
    function automatic fmt_s mk(int c, logic w, logic o);
        return {c[15:0], w, o};
    endfunction : mk
    // Output code expected for one signed data word
    function automatic int clamp12(logic [15:0] w);
        return $signed(w) < 0 ? 0 : (w > 4095 ? 4095 : int'(w));
    endfunction : clamp12
    function automatic int lim(int p);
        return (p >>> 16) > 4095 ? 4095 : p >>> 16;
    endfunction : lim
    // Expected count and flags for one raw code in one range
    function automatic fmt_s exp_fmt(int r, int v);
        case (r)
            1: return v < 1664 ? mk(0, 1, 1) : v < 3200 ? mk(0, 1, 0) : v >= 16384 ? mk(4095, 1, 1)
                : v > 15997 ? mk(4095, 1, 0) : mk(lim((v - 3200) * 20972), 0, 0);
            2: return v == -32768 ? mk(0, 1, 1) : v < -32000 ? mk(0, 1, 0) : v == 32767 ?
                mk(4095, 1, 1) : v > 31984 ? mk(4095, 1, 0) : mk(lim((v + 32000) * 4195), 0, 0);
            3: return v < 0 ? mk(0, 1, 1) : v == 32767 ? mk(32767, 1, 1) : mk(v, v > 32000, 0);
            4: return v < 1664 ? mk(0, 1, 1) : v < 3200 ? mk(0, 1, 0) : v >= 16384 ?
                mk(13184, 1, 1) : mk(v - 3200, 0, v > 16000);
            5: return v == -32768 ? mk(0, 1, 1) : v == 32767 ? mk(65535, 0, 1) :
                mk(v + 32768, v < -32000 || v > 32000, 0);
            default: return v < 0 ? mk(0, 1, 1) : v == 32767 ? mk(4095, 0, 1) : v > 31992 ?
                mk(4095, 1, 0) : mk(lim(v * 8389), 0, 0);
        endcase
    endfunction : exp_fmt
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // Output words: full signed span on one channel, around the clamp edge on the other
    initial begin
        @(posedge reset_n);
        forever begin
            @(posedge mclk);
            #1;
            for (int g = 0; g < 2; g++) begin
                check("aout", aout_code[g], clamp12(aout_word[g]));
            end
            aout_word[0] = 16'($random(seed));
            aout_word[1] = 16'($random(seed)) & 16'h1FFF;
        end
    end
    // Corners in every range first, then random codes and ranges including 6 and 7
    initial begin
        {reset_n, raw, lag, aout_word, st, ch, tp} = '0;
        range_sel = range_unipolar10_12bit;
        repeat (4) @(posedge mclk);
        #1 reset_n = 1;
        for (int i = 0; i < 160; i++) begin
            for (n = 0; conv_req.req !== 1'b1 && n < 100; n++) @(posedge mclk) #1;
            check("req wait", n < 100, 1);
            check("chan", conv_req.chan, ch);
            if (i > 0) check("period", ($time - tp) / 20, RC);
            tp = $time;
            x = i < 120 ? corner[i / 6] : $random(seed);
            r = i < 120 ? i % 6 : $random(seed) & 7;
            raw = 16'(x);
            range_sel = range_e'(r);
            lag = 2'($random(seed));
            e = exp_fmt(r, $signed(raw));
            st[2 * ch] = e.warn;
            st[2 * ch + 1] = e.oor;
            for (n = 0; ain_upd !== 1'b1 && n < 50; n++) @(posedge mclk) #1;
            check("upd wait", n < 50, 1);
            check("upd chan", ain_upd_chan, ch);
            check("count", ain_image[ch], e.count);
            check("count", ain_image[ch], e.count);
            check("count", ain_image[ch], e.count);
            check("status", ain_image[4], st);
            ch = ch + 2'h1;
        end
        $display("Conversion and output tests done");
        finish_test();
    end
    initial begin
        #500000;
        failures++;
        $display("Watchdog expired");
        finish_test();
    end
endmodule : analog_io_count_formatter_test

// ==== verification/conv_front_end.sv ====
// Behavioural converter front end answering the formatter's requests
// ****************************************************************
// Converter model
// ****************************************************************
module conv_front_end
    import analog_io_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire conv_req_s   conv_req,
    input  wire logic [15:0] raw_in,
    input  wire logic [1:0]  lag,
    output conv_rsp_s        conv_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Answer lag+1 cycles after a request; raw toggles so a stale word never looks valid
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt      <= 0;
            conv_rsp <= '0;
        end else begin
            conv_rsp.valid <= (cnt == 1);
            conv_rsp.raw   <= (cnt == 1) ? raw_in : ~conv_rsp.raw;
            cnt            <= conv_req.req ? int'(lag) + 1 : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule : conv_front_end
